// file: rtl/hall_tx_defines.svh
// constants for the measurement package framer
`ifndef HALL_TX_DEFINES_SVH
`define HALL_TX_DEFINES_SVH
`define FRAME_W        13
`define START_HI_POS   12
`define START_LO_POS   11
`define LABEL_HI_POS   10
`define LABEL_LO_POS   9
`define DATA_HI_POS    8
`define DATA_LO_POS    1
`define PARITY_POS     0
`define CNT_RESET      5'h00
`define FIELD_MAX      12'h7FF
`define FIELD_MIN      12'h800
`define DUTY_LO_PERMIL 10'h01E
`define DUTY_MID_PERMIL 10'h1F4
`define DUTY_SPAN_PERMIL 10'h3AC
`define FRAME_GAP_NS   20000
`define FRAME_GAP_CYC  ((`FRAME_GAP_NS + 19) / 20)
`define PWM_PERIOD_CYC 16'h0FA0
`define NV_WORDS       4
`endif

// file: rtl/hall_tx_pkg.sv
// types shared by the framer modules
package hall_tx_pkg;
  typedef logic [12:0] frame_t;
  typedef logic [1:0]  label_t;
  typedef logic [2:0]  err_code_t;
  typedef logic [11:0] field_t;
  typedef enum logic [2:0] {
    ERR_NONE, ERR_ADC_OVF, ERR_ADC_UNF, ERR_NOT_READY,
    ERR_MEM_CHECK, ERR_WDOG, ERR_PROG_CRC, ERR_NV_CRC
  } err_t;
  typedef enum logic [1:0] {
    PH_NV, PH_RUN, PH_PROG
  } phase_t;
endpackage

// file: rtl/nv_shadow_if.sv
// read and write port between framer and nonvolatile shadow store
`timescale 1ns/1ps
interface nv_shadow_if;
  logic [1:0] addr;
  logic [7:0] rdata;
  logic       wen;
  logic [7:0] wdata;
  modport ctrl (output addr, output wen, output wdata, input rdata);
  modport mem  (input addr, input wen, input wdata, output rdata);
endinterface

// file: rtl/nv_shadow_mem.sv
// small nonvolatile content store with registered read data
`timescale 1ns/1ps
`include "hall_tx_defines.svh"
module nv_shadow_mem (
  input  wire logic clk_sys,
  input  wire logic srst,
  nv_shadow_if.mem  bus
);
  logic [7:0] mem_q [`NV_WORDS] = '{default: 8'h00}; // blank until written
  logic [7:0] rdata_q;

  // writes land in storage only; live settings are latched at reset
  always_ff @(posedge clk_sys) begin
    if (bus.wen) begin
      mem_q[bus.addr] <= bus.wdata;
    end
  end

  // registered read keeps memory timing simple
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem_q[bus.addr];
    end
  end

  assign bus.rdata = rdata_q;
endmodule

// file: rtl/hall_sensor_data_package_tx.sv
// measurement package framer with clamp and duty-cycle output
// How it works
// R1: four 13-bit frames, two zero start bits
// R2: label in bits 10:9, sent ascending
// R3: bit 0 makes the frame's ones even
// R4: frame 00: 0, 1, health, counter
// R5: counter five bits, starts at zero
// R6: counter wraps after 11111 to 00000
// R7: health is NOR of non-converter errors
// R8: frame 01 carries 8-bit temperature
// R9: temperature code saturates at 0 and 255
// R10: frame 10: die bit, error, field high
// R11: die bit marks die position
// R12: error code encoding fixed
// R13: frame 11 carries field low byte
// R14: field is 12-bit two's complement
// R15: send nonvolatile content, then stream packages
// R16: programming may interrupt streaming anytime
// R17: new parameters used only after repowering
// R18: field maps linearly to 3..97 percent
// R19: zero gives 50 percent, 94 percent span
// R20: same 16-bit clamp for both modes
// R21: field always saturated to 12 bits
// R22: receiver checks frames, drops bad packages; ecu_rx_model only counts them in badCount and keeps every frame
// R23: memory failure flagged only once at start
// R24: errors only reported, nothing else happens
`timescale 1ns/1ps
`include "hall_tx_defines.svh"
module hall_sensor_data_package_tx
  import hall_tx_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire logic signed [15:0] fieldRaw,
  input  wire logic signed [15:0] tempRaw,
  input  wire logic               dieFar,
  input  wire logic               adcOverflow,
  input  wire logic               adcUnderflow,
  input  wire logic               ifNotReady,
  input  wire logic               memCheckFail,
  input  wire logic               wdogFail,
  input  wire logic               progCrcFail,
  input  wire logic               nvCrcFail,
  input  wire logic signed [15:0] clampLowIn,
  input  wire logic signed [15:0] clampHighIn,
  input  wire logic               progReq,
  input  wire logic [1:0]         progAddr,
  input  wire logic [7:0]         progData,
  input  wire logic               progWrite,
  input  wire logic               frameReady,
  output logic [12:0]             frameData,
  output logic                    frameValid,
  output logic                    nvPhase,
  output logic                    pwmOut,
  output logic [11:0]             fieldOut
);
  import hall_tx_pkg::*;

  nv_shadow_if nvBus ();
  nv_shadow_mem uMem (
    .clk_sys (clk_sys),
    .srst    (srst),
    .bus     (nvBus)
  );

  phase_t            phase_q;
  label_t            label_q;
  logic [4:0]        pkgCnt_q;
  logic [1:0]        nvIdx_q;
  logic              nvRdPend_q;
  logic              memFlagUsed_q;
  logic signed [15:0] clampLo_q;
  logic signed [15:0] clampHi_q;
  logic              clampLoaded_q;
  logic [11:0]       fieldSnap_q;
  logic [7:0]        tempSnap_q;
  err_code_t         errSnap_q;
  logic              okSnap_q;
  logic              dieSnap_q;
  logic [15:0]       pwmCnt_q;
  logic [15:0]       pwmHigh_q;
  logic [11:0]       fieldClamped;
  logic [7:0]        tempCode;
  err_code_t         errNow;
  logic              okNow;
  logic              sendFrame;

  // even parity over bits 12..1 so total ones stay even
  function automatic frame_t build_frame(label_t lab, logic [7:0] dat);
    frame_t f;
    f = {2'b00, lab, dat, 1'b0}; // [R1]
    f[`PARITY_POS] = ^f[12:1]; // [R3]
    return f;
  endfunction

  // clamp a signed value between two signed limits
  function automatic logic signed [15:0] clamp16(
    logic signed [15:0] v, logic signed [15:0] lo, logic signed [15:0] hi);
    logic signed [15:0] r;
    r = v;
    if (r < lo) begin
      r = lo;
    end
    if (r > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // last frame of a package accepted by the line driver
  function automatic logic pkg_end(logic taken, label_t lab);
    return taken && (lab == 2'b11);
  endfunction

  // field path: 12-bit saturation then programmed limits
  always_comb begin
    logic signed [15:0] s;
    s = clamp16(fieldRaw, 16'hF800, 16'h07FF); // [R21] [R14]
    s = clamp16(s, clampLo_q, clampHi_q); // [R20]
    fieldClamped = s[11:0];
  end

  // temperature code saturates at the range ends
  always_comb begin
    if (tempRaw < 16'sh0000) begin
      tempCode = 8'h00; // [R9]
    end else if (tempRaw > 16'sh00FF) begin
      tempCode = 8'hFF; // [R9]
    end else begin
      tempCode = tempRaw[7:0];
    end
  end

  // highest-priority error wins the 3-bit code
  always_comb begin
    errNow = ERR_NONE; // [R12]
    if (adcOverflow) begin
      errNow = ERR_ADC_OVF;
    end
    if (adcUnderflow) begin
      errNow = ERR_ADC_UNF;
    end
    if (ifNotReady) begin
      errNow = ERR_NOT_READY;
    end
    if (memCheckFail && !memFlagUsed_q) begin
      errNow = ERR_MEM_CHECK; // [R23]
    end
    if (wdogFail) begin
      errNow = ERR_WDOG;
    end
    if (progCrcFail) begin
      errNow = ERR_PROG_CRC;
    end
    if (nvCrcFail) begin
      errNow = ERR_NV_CRC;
    end
    // converter range errors do not lower the health bit
    okNow = !(ifNotReady || (memCheckFail && !memFlagUsed_q) ||
              wdogFail || progCrcFail || nvCrcFail); // [R7] [R24]
  end

  assign sendFrame = frameValid && frameReady && !progReq; // [R16]

  // phase sequencing: nonvolatile dump, then run, programming pauses
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase_q <= PH_NV;
    end else if (progReq) begin
      phase_q <= PH_PROG; // [R16]
    end else if (phase_q == PH_PROG) begin
      phase_q <= PH_RUN;
    end else if (phase_q == PH_NV && pkg_end(sendFrame, label_q) &&
                 nvIdx_q == 2'(`NV_WORDS - 1)) begin
      phase_q <= PH_RUN; // [R15]
    end
  end

  // label walks 00..11, one step per accepted frame
  always_ff @(posedge clk_sys) begin
    if (srst || progReq || phase_q == PH_PROG) begin
      label_q <= 2'b00;
    end else if (sendFrame) begin
      label_q <= label_q + 2'b01; // [R2]
    end
  end

  // nonvolatile dump index advances once per package
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      nvIdx_q <= 2'b00;
    end else if (phase_q == PH_NV && pkg_end(sendFrame, label_q)) begin
      nvIdx_q <= nvIdx_q + 2'b01;
    end
  end

  // package counter counts measurement packages only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pkgCnt_q <= `CNT_RESET; // [R5]
    end else if (phase_q == PH_RUN && pkg_end(sendFrame, label_q)) begin
      pkgCnt_q <= pkgCnt_q + 5'h01; // [R6]
    end
  end

  // memory-test failure is reported until the first measurement package ends
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      memFlagUsed_q <= 1'b0;
    end else if (phase_q == PH_RUN && pkg_end(sendFrame, label_q)) begin
      memFlagUsed_q <= 1'b1; // [R23]
    end
  end

  // limits latched once after reset; later writes wait for a power cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clampLoaded_q <= 1'b0;
      clampLo_q <= 16'sh8000;
      clampHi_q <= 16'sh7FFF;
    end else if (!clampLoaded_q) begin
      clampLoaded_q <= 1'b1;
      clampLo_q <= clampLowIn; // [R17]
      clampHi_q <= clampHighIn; // [R17]
    end
  end

  // snapshot a whole package at label 00 so frames stay coherent
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fieldSnap_q <= 12'h000;
      tempSnap_q <= 8'h00;
      errSnap_q <= 3'h0;
      okSnap_q <= 1'b1;
      dieSnap_q <= 1'b0;
    end else if (label_q == 2'b00 && !frameValid) begin
      fieldSnap_q <= fieldClamped;
      tempSnap_q <= tempCode;
      errSnap_q <= errNow;
      okSnap_q <= okNow;
      dieSnap_q <= dieFar; // [R11]
    end
  end

  // programming port writes the store; reads feed the dump
  assign nvBus.addr = (phase_q == PH_PROG) ? progAddr : nvIdx_q;
  assign nvBus.wen = (phase_q == PH_PROG) && progWrite;
  assign nvBus.wdata = progData;

  // frame assembly and handshake with the line driver
  always_ff @(posedge clk_sys) begin
    if (srst || progReq || phase_q == PH_PROG) begin // [R16]
      frameValid <= 1'b0;
      frameData <= 13'h0000;
      nvRdPend_q <= 1'b1;
    end else if (nvRdPend_q) begin
      nvRdPend_q <= 1'b0; // wait one cycle for registered read
    end else if (!frameValid || frameReady) begin
      frameValid <= 1'b1;
      if (pkg_end(sendFrame, label_q)) begin
        frameValid <= 1'b0; // reload snapshot between packages
        nvRdPend_q <= 1'b1;
      end else begin
        unique case (sendFrame ? label_q + 2'b01 : label_q)
          2'b00: frameData <= (phase_q == PH_NV) ?
            build_frame(2'b00, nvBus.rdata) :
            build_frame(2'b00, {2'b01, okSnap_q, pkgCnt_q}); // [R4]
          2'b01: frameData <= build_frame(2'b01,
            (phase_q == PH_NV) ? nvBus.rdata : tempSnap_q); // [R8]
          2'b10: frameData <= build_frame(2'b10,
            {dieSnap_q, errSnap_q, fieldSnap_q[11:8]}); // [R10]
          2'b11: frameData <= build_frame(2'b11,
            fieldSnap_q[7:0]); // [R13]
        endcase
      end
    end
  end

  // flag for the line driver during the nonvolatile dump
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      nvPhase <= 1'b1;
    end else begin
      nvPhase <= (phase_q == PH_NV);
    end
  end

  // duty = 50% + field*47%/2048, zero gives exactly half
  always_ff @(posedge clk_sys) begin
    logic signed [31:0] prod;
    prod = 32'(signed'(fieldClamped)) * 32'sh0000_0758;
    if (srst) begin
      pwmCnt_q <= 16'h0000;
      pwmHigh_q <= 16'h07D0;
      fieldOut <= 12'h000;
    end else begin
      fieldOut <= fieldClamped; // [R20]
      pwmCnt_q <= (pwmCnt_q == `PWM_PERIOD_CYC - 16'h0001) ?
                  16'h0000 : pwmCnt_q + 16'h0001;
      if (pwmCnt_q == 16'h0000) begin
        pwmHigh_q <= 16'(32'sh0000_07D0 + (prod >>> 11)); // [R18] [R19]
      end
    end
  end

  // duty output level from registered compare
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= (pwmCnt_q < pwmHigh_q);
    end
  end
endmodule

// file: verification/hall_tx_assertions.sv
// port checker for the package framer
`timescale 1ns/1ps
module hall_tx_assertions (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        progReq,
  input wire logic        frameReady,
  input wire logic [12:0] frameData,
  input wire logic        frameValid,
  input wire logic        nvPhase,
  input wire logic        pwmOut,
  input wire logic [11:0] fieldOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // label field and handshake shorthand
  wire [1:0] lbl = frameData[10:9];
  wire       take = frameValid && frameReady;
  start_bits_a: assert property (
    frameValid |-> frameData[12:11] == 2'h0) else $error("start bit set");
  even_parity_a: assert property (
    frameValid |-> !(^frameData)) else $error("odd frame parity");
  label_step_a: assert property (
    take && lbl != 2'h3 && !progReq |=> frameValid && lbl == $past(lbl) + 2'h1)
    else $error("label out of order");
  package_gap_a: assert property (
    take && lbl == 2'h3 |=> !frameValid [*2]) else $error("no package gap");
  restart_label_a: assert property (
    $rose(frameValid) |-> lbl == 2'h0) else $error("package not at label 0");
  prog_stop_a: assert property (
    progReq |=> !frameValid) else $error("frame during programming");
  head_bits_a: assert property (
    frameValid && lbl == 2'h0 && !nvPhase |-> frameData[8:7] == 2'h1)
    else $error("first frame head wrong");
  reset_state_a: assert property (disable iff (1'b0)
    srst |=> !frameValid && nvPhase && !pwmOut && fieldOut == 12'h000)
    else $error("reset state wrong");
endmodule

bind hall_sensor_data_package_tx hall_tx_assertions chk (.clk_sys, .srst,
  .progReq, .frameReady, .frameData, .frameValid, .nvPhase, .pwmOut,
  .fieldOut);

// file: verification/ecu_rx_model.sv
// control unit model: takes frames, checks them, can stall
`timescale 1ns/1ps
module ecu_rx_model (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        progReq,
  input  wire logic        accept,
  input  wire logic        slow,
  input  wire logic [12:0] frameData,
  input  wire logic        frameValid,
  output logic             frameReady
);
  logic [12:0] rxQ[$];
  logic [1:0]  nextLbl;
  logic        tgl;
  int          badCount = 0;
  // slow mode drops ready every other cycle; no ready while programming
  always @(posedge clk_sys) begin
    tgl <= srst ? 1'b0 : !tgl;
    frameReady <= !srst && !progReq && accept && (!slow || tgl);
  end
  // a frame with bad start bits, label order or parity adds one to badCount, however many of these it has; the frame is still queued
  always @(posedge clk_sys) begin
    if (srst || progReq) begin
      nextLbl = 2'h0;
      if (srst) rxQ.delete();
    end else if (frameValid && frameReady) begin
      if (frameData[12:11] !== 2'h0 || frameData[10:9] !== nextLbl ||
          ^frameData !== 1'b0) badCount++;
      nextLbl = frameData[10:9] + 2'h1;
      rxQ.push_back(frameData);
    end
  end
endmodule

// file: verification/hall_sensor_data_package_tx_test.sv
// self-checking bench for the package framer
`timescale 1ns/1ps
module hall_sensor_data_package_tx_test;
  import hall_tx_pkg::*;
  logic               clk_sys, srst, dieFar, progReq, progWrite;
  logic               accept, slow, meas, frameValid, nvPhase, pwmOut;
  logic               frameReady;
  logic signed [15:0] fieldRaw, tempRaw, clampLowIn, clampHighIn;
  logic [6:0]         errV;
  logic [1:0]         progAddr = 2'h1;
  logic [7:0]         progData = 8'hA5;
  logic [4:0]         cnt;
  frame_t             frameData;
  field_t             fieldOut;
  frame_t             pk[4];
  int                 n_mismatch, check_count;
  hall_sensor_data_package_tx dut (.clk_sys, .srst, .fieldRaw, .tempRaw,
    .dieFar, .adcOverflow(errV[0]), .adcUnderflow(errV[1]),
    .ifNotReady(errV[2]), .memCheckFail(errV[3]), .wdogFail(errV[4]),
    .progCrcFail(errV[5]), .nvCrcFail(errV[6]), .clampLowIn, .clampHighIn,
    .progReq, .progAddr, .progData, .progWrite, .frameReady, .frameData,
    .frameValid, .nvPhase, .pwmOut, .fieldOut);
  ecu_rx_model ecu (.clk_sys, .srst, .progReq, .accept, .slow, .frameData,
    .frameValid, .frameReady);
  // clock and hang guard
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (100000) @(negedge clk_sys);
    n_mismatch++;
    print_verdict();
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input frame_t e, input frame_t g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic frame_t mk(input label_t l, input logic [7:0] b);
    return {2'h0, l, b, ^{l, b}};
  endfunction
  // waits boundedly for a whole package from the control unit model
  task automatic get_pkg();
    int n;
    n = 0;
    while (ecu.rxQ.size() < 4 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 300) n_mismatch++;
    if (n >= 300) print_verdict();
    for (int i = 0; i < 4; i++) pk[i] = ecu.rxQ.pop_front();
    if (meas) chk("counter", {8'h0, cnt}, {8'h0, pk[0][5:1]});
    cnt++;
  endtask
  // third package after an input change carries the new values
  task automatic chk_pkg(input logic h, input logic [7:0] t,
                         input err_code_t e, input field_t f);
    repeat (3) get_pkg();
    chk("frame0", mk(2'h0, {2'h1, h, pk[0][5:1]}), pk[0]);
    chk("frame1", mk(2'h1, t), pk[1]);
    chk("frame2", mk(2'h2, {dieFar, e, f[11:8]}), pk[2]);
    chk("frame3", mk(2'h3, f[7:0]), pk[3]);
    chk("fieldOut", {1'h0, f}, {1'h0, fieldOut});
  endtask
  task automatic do_reset(input logic [15:0] lo, input logic [15:0] hi);
    clampLowIn = lo;
    clampHighIn = hi;
    srst = 1;
    repeat (16) @(negedge clk_sys);
    chk("nvPhase", 13'h1, {12'h0, nvPhase});
    srst = 0;
    meas = 0;
    repeat (4) get_pkg();
    meas = 1;
    cnt = 0;
  endtask
  // high time of one full period after the field settles
  task automatic pwm(input logic [15:0] f, input int hi);
    int n, c;
    fieldRaw = f;
    accept = 0;
    n = 0;
    c = 0;
    repeat (2) begin
      while (pwmOut !== 1'b0 && n < 9000) begin @(negedge clk_sys); n++; end
      while (pwmOut !== 1'b1 && n < 9000) begin @(negedge clk_sys); n++; end
    end
    while (pwmOut === 1'b1 && c < 5000) begin @(negedge clk_sys); c++; end
    if (n >= 9000) n_mismatch++;
    chk("pwm high", 13'(hi), 13'(c));
    accept = 1;
  endtask
  initial begin
    {srst, dieFar, accept, progReq, progWrite, slow, meas} = 7'h70;
    {errV, n_mismatch, check_count} = '0;
    fieldRaw = 16'h0123;
    tempRaw = 16'h0064;
    do_reset(16'h8000, 16'h7FFF);
    chk_pkg(1'h1, 8'h64, 3'h0, 12'h123);
    chk("nvPhase", 13'h0, {12'h0, nvPhase});
    $display("test base done");
    dieFar = 0;
    for (int k = 0; k < 7; k++) begin
      errV = 7'h1 << k;
      chk_pkg(!(k inside {2, 4, 5, 6}), 8'h64,
              (k == 3) ? 3'h0 : 3'(k + 1), 12'h123);
    end
    $display("test errors done");
    {errV, slow, fieldRaw, tempRaw} = {8'h1, 32'h7FFF_0200};
    chk_pkg(1'h1, 8'hFF, 3'h0, 12'h7FF);
    {fieldRaw, tempRaw} = 32'h8000_FFFB;
    chk_pkg(1'h1, 8'h00, 3'h0, 12'h800);
    slow = 0;
    $display("test saturation done");
    pwm(16'h0000, 2000);
    pwm(16'h7FFF, 3879);
    pwm(16'h8000, 120);
    $display("test duty done");
    {fieldRaw, tempRaw, progReq} = {32'h0123_0064, 1'h1};
    @(negedge clk_sys);
    {progWrite, meas} = 2'h2;
    ecu.rxQ.delete();
    @(negedge clk_sys);
    progWrite = 0;
    repeat (8) @(negedge clk_sys);
    progReq = 0;
    chk_pkg(1'h1, 8'h64, 3'h0, 12'h123);
    $display("test programming done");
    errV = 7'h08;
    do_reset(16'hF931, 16'h06CE);
    get_pkg();
    chk("mem health", mk(2'h0, 8'h40), pk[0]);
    chk("mem code", mk(2'h2, 8'h41), pk[2]);
    fieldRaw = 16'h07D0;
    chk_pkg(1'h1, 8'h64, 3'h0, 12'h6CE);
    errV = 7'h00;
    fieldRaw = 16'hF830;
    chk_pkg(1'h1, 8'h64, 3'h0, 12'h931);
    repeat (28) get_pkg();
    chk("bad frames", 13'h0, 13'(ecu.badCount));
    $display("test clamp done");
    print_verdict();
  end
endmodule
